// file: verilog/drs_selector.sv
// drive reference selector: panel modes, reference and loop control
// assumes keys and digital inputs are asynchronous pins; all other
// inputs come from logic on CLK_SYS_I
`timescale 1ns/1ns
module drs_selector #(
  parameter int TICK_CYCLES = drs_pkg::TICK_CYC
) (
  // clock and reset
  input  wire logic                                   CLK_SYS_I,
  input  wire logic                                   RESET_I,
  // panel keys and digital input pins
  input  wire logic                                   HAND_KEY_I,
  input  wire logic                                   OFF_KEY_I,
  input  wire logic                                   AUTO_KEY_I,
  input  wire logic                                   RESET_KEY_I,
  input  wire logic                                   NAV_UP_I,
  input  wire logic                                   NAV_DOWN_I,
  input  wire logic                                   POT_INC_I,
  input  wire logic                                   POT_DEC_I,
  input  wire logic                                   POT_CLR_I,
  input  wire logic [2:0]                             PRESET_DI_I,
  // remote commands
  input  wire logic                                   REMOTE_RUN_I,
  input  wire logic [2:0]                             PRESET_BUS_I,
  input  wire logic                                   PRESET_FROM_BUS_I,
  input  wire drs_pkg::drs_ref_t                      BUS_REF_I,
  // configuration
  input  wire logic [3:0]                             KEY_PERMIT_I,
  input  wire logic [1:0]                             LOOP_MODE_I,
  input  wire drs_pkg::drs_site_e                     REF_SITE_I,
  input  wire drs_pkg::drs_rfunc_e                    REF_FUNC_I,
  input  wire drs_pkg::drs_src_e [2:0]                SRC_SEL_I,
  input  wire drs_pkg::drs_ref_t [drs_pkg::PRESET_N-1:0] PRESET_REF_I,
  input  wire drs_pkg::drs_ref_t                      REL_PCT_I,
  input  wire drs_pkg::drs_ref_t                      RAMP_STEP_I,
  input  wire drs_pkg::drs_ref_t                      SPEED_MIN_I,
  input  wire drs_pkg::drs_ref_t                      SPEED_MAX_I,
  input  wire drs_pkg::drs_ref_t                      FREQ_MAX_I,
  // reference sources and feedback
  input  wire drs_pkg::drs_ref_t                      ANALOG_REF_I,
  input  wire drs_pkg::drs_ref_t                      FREQ_REF_I,
  input  wire drs_pkg::drs_ref_t                      EXT_CL_REF_I,
  input  wire drs_pkg::drs_ref_t [2:0]                FB_I,
  input  wire drs_pkg::drs_ref_t [2:0]                SP_I,
  input  wire drs_pkg::drs_fbf_e                      FB_FUNC_I,
  input  wire logic [2:0]                             FB_SQRT_I,
  input  wire logic                                   ZONE3_I,
  input  wire drs_pkg::drs_ref_t                      LOCAL_REF_NV_I,
  // outputs
  output logic                                        RUN_O,
  output drs_pkg::drs_hand_auto_e                     MODE_O,
  output logic                                        LOCAL_ACTIVE_O,
  output logic                                        CLOSED_LOOP_O,
  output logic                                        ALARM_CLEAR_O,
  output drs_pkg::drs_ref_t                           LOCAL_REF_O,
  output drs_pkg::drs_ref_t                           ACTIVE_REF_O,
  output drs_pkg::drs_ref_t                           CTL_ERROR_O,
  output drs_pkg::drs_ref_t                           MOTOR_REF_O
);
  import drs_pkg::*;

  logic [N_IN-1:0] pin_w, s1_q, s2_q, s3_q, flt_q, press_w;
  logic [2:0]      key_go_w;
  logic [15:0]     tick_cnt_q;
  logic            tick_q, restore_q, local_d;
  drs_hand_auto_e  st_q;
  drs_ref_t        local_q, pot_q, act_q, ctl_q, err_q, motor_q, x_w, scaled_w;
  drs_ref_t        ext_w, preset_w, sp_eff_w, target_w, ramp_w, lim_w;
  logic signed [31:0] y_w, ext_acc_w, err_w;
  logic [2:0]      ps_sel_w;
  drs_fb_if        fbi ();

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  assign pin_w = {PRESET_DI_I, POT_CLR_I, POT_DEC_I, POT_INC_I, NAV_DOWN_I, NAV_UP_I,
                  RESET_KEY_I, AUTO_KEY_I, OFF_KEY_I, HAND_KEY_I};
  for (genvar i = 0; i < N_IN; i++) begin : g_sync
    always_ff @(posedge CLK_SYS_I) begin
      if (RESET_I) begin
        s1_q[i]  <= 1'b0;
        s2_q[i]  <= 1'b0;
        s3_q[i]  <= 1'b0;
        flt_q[i] <= 1'b0;
      end else begin
        s1_q[i] <= pin_w[i];
        s2_q[i] <= s1_q[i];
        s3_q[i] <= s2_q[i];
        if (s2_q[i] == s3_q[i]) flt_q[i] <= s3_q[i];
      end
    end
    assign press_w[i] = (s2_q[i] == s3_q[i]) & s3_q[i] & ~flt_q[i];
  end

  // ---------------------------------------------------------------
  // control tick
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      tick_cnt_q <= 16'h0000;
      tick_q     <= 1'b0;
    end else begin
      tick_q <= (tick_cnt_q == 16'(TICK_CYCLES - 1));
      tick_cnt_q <= (tick_cnt_q == 16'(TICK_CYCLES - 1)) ? 16'h0000 : tick_cnt_q + 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // panel keys and manual/automatic state
  // ---------------------------------------------------------------
  assign key_go_w = press_w[K_AUTO:K_HAND] & KEY_PERMIT_I[K_AUTO:K_HAND];
  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      st_q          <= HA_AUTO_OFF;
      ALARM_CLEAR_O <= 1'b0;
      RUN_O         <= 1'b0;
    end else begin
      if (key_go_w[K_HAND]) st_q <= HA_HAND;
      else if (key_go_w[K_AUTO]) st_q <= HA_AUTO;
      else if (key_go_w[K_OFF]) st_q <= st_q[1] ? HA_AUTO_OFF : HA_HAND_OFF;
      ALARM_CLEAR_O <= press_w[K_RST] & KEY_PERMIT_I[K_RST];
      RUN_O <= (st_q == HA_HAND) | ((st_q == HA_AUTO) & REMOTE_RUN_I);
    end
  end

  // ---------------------------------------------------------------
  // reference origin and loop mode
  // ---------------------------------------------------------------
  always_comb begin
    unique case (REF_SITE_I)
      SITE_LOCAL:  local_d = 1'b1;
      SITE_REMOTE: local_d = 1'b0;
      default:     local_d = ~st_q[1];
    endcase
  end
  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      LOCAL_ACTIVE_O <= 1'b0;
      CLOSED_LOOP_O  <= 1'b0;
    end else begin
      LOCAL_ACTIVE_O <= local_d;
      CLOSED_LOOP_O  <= (LOOP_MODE_I != LOOP_OPEN) & ~local_d;
    end
  end

  // ---------------------------------------------------------------
  // local reference with restore after power-up
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      restore_q <= 1'b1;
      local_q   <= '0;
    end else if (restore_q) begin
      restore_q <= 1'b0;
      local_q   <= LOCAL_REF_NV_I;
    end else if (st_q == HA_HAND && press_w[K_UP]) begin
      local_q <= sat(32'(local_q) + 32'(LOCAL_STEP));
    end else if (st_q == HA_HAND && press_w[K_DN]) begin
      local_q <= sat(32'(local_q) - 32'(LOCAL_STEP));
    end
  end
  assign LOCAL_REF_O = local_q;

  // ---------------------------------------------------------------
  // remote reference assembly
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      pot_q <= '0;
    end else if (tick_q) begin
      if (flt_q[D_CLR]) pot_q <= '0;
      else if (flt_q[D_INC]) pot_q <= sat(32'(pot_q) + 32'(POT_STEP));
      else if (flt_q[D_DEC]) pot_q <= sat(32'(pot_q) - 32'(POT_STEP));
    end
  end

  always_comb begin
    ext_acc_w = 32'(BUS_REF_I);
    for (int i = 0; i < 3; i++) begin
      unique case (SRC_SEL_I[i])
        SRC_ANALOG: ext_acc_w = ext_acc_w + 32'(ANALOG_REF_I);
        SRC_FREQ:   ext_acc_w = ext_acc_w + 32'(FREQ_REF_I);
        SRC_EXT_CL: ext_acc_w = ext_acc_w + 32'(EXT_CL_REF_I);
        SRC_POT:    ext_acc_w = ext_acc_w + 32'(pot_q);
        default:    ext_acc_w = ext_acc_w;
      endcase
    end
  end
  assign ext_w    = sat(ext_acc_w);
  assign ps_sel_w = PRESET_FROM_BUS_I ? PRESET_BUS_I : flt_q[D_PS0 +: 3];
  assign preset_w = PRESET_REF_I[ps_sel_w];

  always_comb begin
    unique case (REF_FUNC_I)
      RF_PRESET: x_w = preset_w;
      RF_SUM:    x_w = sat(32'(ext_w) + 32'(preset_w));
      default:   x_w = ext_w;
    endcase
  end
  assign y_w = (32'(REL_PCT_I) > PCT_MAX) ? PCT_MAX :
               (32'(REL_PCT_I) < -PCT_MAX) ? -PCT_MAX : 32'(REL_PCT_I);
  assign scaled_w = sat(32'(x_w) + (32'(x_w) * y_w) / PCT_DIV);

  // ---------------------------------------------------------------
  // feedback, closed loop controller
  // ---------------------------------------------------------------
  assign fbi.fb      = FB_I;
  assign fbi.sp      = SP_I;
  assign fbi.func    = FB_FUNC_I;
  assign fbi.sqrt_en = FB_SQRT_I;
  assign fbi.zone3   = ZONE3_I;
  drs_fb_comb u_fb (
    .fb (fbi)
  );
  assign sp_eff_w = fbi.single ? sat(32'(fbi.sel_sp) + 32'(act_q)) : fbi.sel_sp;
  assign err_w    = 32'(sp_eff_w) - 32'(fbi.sel_fb);

  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      act_q <= '0;
      err_q <= '0;
      ctl_q <= '0;
    end else if (tick_q) begin
      act_q <= scaled_w;
      err_q <= sat(err_w);
      if (CLOSED_LOOP_O) ctl_q <= sat(32'(ctl_q) + (err_w >>> CTL_SHIFT));
      else ctl_q <= motor_q;
    end
  end
  assign ACTIVE_REF_O = act_q;
  assign CTL_ERROR_O  = err_q;

  // ---------------------------------------------------------------
  // ramp, speed limit and frequency ceiling
  // ---------------------------------------------------------------
  assign target_w = CLOSED_LOOP_O ? ctl_q : (LOCAL_ACTIVE_O ? local_q : act_q);
  assign ramp_w = (32'(target_w) > 32'(motor_q) + 32'(RAMP_STEP_I)) ?
                    sat(32'(motor_q) + 32'(RAMP_STEP_I)) :
                  (32'(target_w) < 32'(motor_q) - 32'(RAMP_STEP_I)) ?
                    sat(32'(motor_q) - 32'(RAMP_STEP_I)) : target_w;
  assign lim_w = (ramp_w > SPEED_MAX_I) ? SPEED_MAX_I :
                 (ramp_w < SPEED_MIN_I) ? SPEED_MIN_I : ramp_w;
  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) motor_q <= '0;
    else if (tick_q) motor_q <= (lim_w > FREQ_MAX_I) ? FREQ_MAX_I : lim_w;
  end
  assign MOTOR_REF_O = motor_q;
  assign MODE_O      = st_q;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (RESET_I);

  sequence s_hand_press;
    press_w[K_HAND] && KEY_PERMIT_I[K_HAND];
  endsequence
  sequence s_rst_press;
    press_w[K_RST] && KEY_PERMIT_I[K_RST];
  endsequence

  AST_LOCAL_OPEN: assert property (LOCAL_ACTIVE_O |-> !CLOSED_LOOP_O)
    else $error("closed loop while local reference active");
  AST_MOTOR_MAX: assert property (tick_q |=> MOTOR_REF_O <= $past(FREQ_MAX_I))
    else $error("motor reference above frequency ceiling");
  AST_HAND_KEY: assert property (s_hand_press |=> MODE_O == HA_HAND ##1 RUN_O)
    else $error("manual key did not enter manual run");
  AST_NO_PERMIT: assert property (key_go_w == 3'b000 |=> $stable(MODE_O))
    else $error("mode changed without permitted key");
  AST_ALARM_CLR: assert property (s_rst_press |=> ALARM_CLEAR_O)
    else $error("permitted reset key did not clear alarms");
  AST_SITE_LOCAL: assert property (REF_SITE_I == SITE_LOCAL |=> LOCAL_ACTIVE_O)
    else $error("fixed local origin not honoured");
  AST_POT_CLR: assert property (tick_q && flt_q[D_CLR] |=> pot_q == '0)
    else $error("potentiometer not cleared");
  AST_REL_ZERO: assert property (tick_q && REL_PCT_I == '0 |=> ACTIVE_REF_O == $past(x_w))
    else $error("zero percentage changed the reference");
  AST_RESTORE: assert property (restore_q |=> LOCAL_REF_O == $past(LOCAL_REF_NV_I))
    else $error("local reference not restored");

endmodule : drs_selector

// file: verilog/drs_pkg.sv
// constants, types and helpers for the drive reference selector
// assumes one 25 mhz system clock; references in 0.01 % steps
package drs_pkg;

  // ---------------------------------------------------------------
  // number formats
  // ---------------------------------------------------------------
  localparam int REF_W = 16;
  typedef logic signed [REF_W-1:0] drs_ref_t;
  localparam drs_ref_t          REF_MAX     = 16'sh4e20;
  localparam drs_ref_t          REF_MIN     = -16'sh4e20;
  localparam logic signed [31:0] PCT_MAX    = 32'sh0000_00c8;
  localparam logic signed [31:0] PCT_DIV    = 32'sh0000_0064;
  localparam logic [31:0]       SQRT_SCALE  = 32'h0000_2710;
  localparam drs_ref_t          LOCAL_STEP  = 16'sh0064;
  localparam drs_ref_t          POT_STEP    = 16'sh000a;
  localparam int                CTL_SHIFT   = 4;
  localparam int                PRESET_N    = 8;
  localparam logic [1:0]        LOOP_OPEN   = 2'h0;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int CLK_PERIOD_NS  = 40;
  localparam int TICK_CYC       = TICK_PERIOD_NS / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // synchronised pin indices and key permit bits
  // ---------------------------------------------------------------
  localparam int K_HAND = 0;
  localparam int K_OFF  = 1;
  localparam int K_AUTO = 2;
  localparam int K_RST  = 3;
  localparam int K_UP   = 4;
  localparam int K_DN   = 5;
  localparam int D_INC  = 6;
  localparam int D_DEC  = 7;
  localparam int D_CLR  = 8;
  localparam int D_PS0  = 9;
  localparam int N_IN   = 12;

  // ---------------------------------------------------------------
  // modes
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    HA_HAND = 2'b00, HA_HAND_OFF = 2'b01, HA_AUTO = 2'b10, HA_AUTO_OFF = 2'b11
  } drs_hand_auto_e;
  typedef enum logic [1:0] {
    SITE_LINKED = 2'b00, SITE_LOCAL = 2'b01, SITE_REMOTE = 2'b10
  } drs_site_e;
  typedef enum logic [2:0] {
    SRC_NONE = 3'b000, SRC_ANALOG = 3'b001, SRC_FREQ = 3'b010,
    SRC_EXT_CL = 3'b011, SRC_POT = 3'b100
  } drs_src_e;
  typedef enum logic [1:0] {
    RF_EXT = 2'b00, RF_PRESET = 2'b01, RF_SUM = 2'b10
  } drs_rfunc_e;
  typedef enum logic [3:0] {
    FBF_FB1 = 4'h0, FBF_FB2 = 4'h1, FBF_FB3 = 4'h2, FBF_SUM = 4'h3,
    FBF_DIFF = 4'h4, FBF_AVG = 4'h5, FBF_MIN = 4'h6, FBF_MAX = 4'h7,
    FBF_MSP_MIN = 4'hd, FBF_MSP_MAX = 4'he
  } drs_fbf_e;

  function automatic drs_ref_t sat(input logic signed [31:0] v);
    if (v > REF_MAX) return REF_MAX;
    if (v < REF_MIN) return REF_MIN;
    return v[REF_W-1:0];
  endfunction : sat

endpackage : drs_pkg

// file: verilog/drs_fb_if.sv
// carrier between the selector and its feedback combiner
// assumes both ends sit on the same clock
`timescale 1ns/1ns
interface drs_fb_if;
  import drs_pkg::*;
  drs_ref_t [2:0] fb;
  drs_ref_t [2:0] sp;
  drs_fbf_e       func;
  logic [2:0]     sqrt_en;
  logic           zone3;
  drs_ref_t       sel_sp;
  drs_ref_t       sel_fb;
  logic           single;
  modport ctl  (output fb, sp, func, sqrt_en, zone3, input sel_sp, sel_fb, single);
  modport comb (input fb, sp, func, sqrt_en, zone3, output sel_sp, sel_fb, single);
endinterface : drs_fb_if

// file: verilog/drs_fb_comb.sv
// feedback conversion and zone combination, purely combinational
// assumes the selector samples the result on its control tick
`timescale 1ns/1ns
module drs_fb_comb (
  drs_fb_if.comb fb
);
  import drs_pkg::*;

  // ---------------------------------------------------------------
  // square root, result kept in 0.01 % units
  // ---------------------------------------------------------------
  function automatic drs_ref_t root_pct(input drs_ref_t v);
    logic [31:0] rad;
    logic [31:0] res;
    logic [31:0] bv;
    rad = (v < 0) ? 32'h0 : {16'h0000, v} * SQRT_SCALE;
    res = 32'h0;
    bv  = 32'h4000_0000;
    for (int k = 0; k < 16; k++) begin
      if (rad >= res + bv) begin
        rad = rad - (res + bv);
        res = (res >> 1) + bv;
      end else begin
        res = res >> 1;
      end
      bv = bv >> 2;
    end
    return drs_ref_t'(res[REF_W-1:0]);
  endfunction : root_pct

  // ---------------------------------------------------------------
  // combination
  // ---------------------------------------------------------------
  always_comb begin
    drs_ref_t [2:0]     fe;
    logic signed [31:0] acc;
    logic signed [31:0] best;
    logic signed [31:0] d;
    int                 n;
    int                 k;
    fe   = '0;
    acc  = '0;
    best = '0;
    d    = '0;
    n    = fb.zone3 ? 3 : 2;
    k    = 0;
    for (int i = 0; i < 3; i++) begin
      fe[i] = fb.sqrt_en[i] ? root_pct(fb.fb[i]) : fb.fb[i];
    end
    fb.sel_sp = fb.sp[0];
    fb.sel_fb = fe[0];
    fb.single = 1'b0;
    unique case (fb.func)
      FBF_FB1, FBF_FB2, FBF_FB3: begin
        fb.single = 1'b1;
        fb.sel_fb = fe[fb.func[1:0]];
      end
      FBF_SUM, FBF_AVG: begin
        for (int i = 0; i < 3; i++) begin
          if (i < n) acc = acc + 32'(fe[i]);
        end
        if (fb.func == FBF_AVG) acc = acc / n;
        fb.sel_fb = sat(acc);
      end
      FBF_DIFF: begin
        fb.sel_fb = sat(32'(fe[0]) - 32'(fe[1]));
      end
      FBF_MIN, FBF_MAX: begin
        best = 32'(fe[0]);
        for (int i = 1; i < 3; i++) begin
          if (i < n && ((fb.func == FBF_MIN) ? (32'(fe[i]) < best)
                                             : (32'(fe[i]) > best))) begin
            best = 32'(fe[i]);
          end
        end
        fb.sel_fb = best[REF_W-1:0];
      end
      FBF_MSP_MIN, FBF_MSP_MAX: begin
        best = 32'(fb.sp[0]) - 32'(fe[0]);
        for (int i = 1; i < 3; i++) begin
          d = 32'(fb.sp[i]) - 32'(fe[i]);
          if (i < n && ((fb.func == FBF_MSP_MIN) ? (d > best) : (d < best))) begin
            best = d;
            k    = i;
          end
        end
        fb.sel_sp = fb.sp[k];
        fb.sel_fb = fe[k];
      end
      default: begin
        fb.sel_fb = fe[0];
      end
    endcase
  end

endmodule : drs_fb_comb

// file: verif/drs_panel_model.sv
// operator panel model: key levels for the selector bench
// assumes a 3-flop key filter inside the block
`timescale 1ns/1ns
module drs_panel_model (
  // clock
  input  wire logic clk_i,
  // hand, off, auto, reset, up, down
  output logic [5:0] key_o
);
  initial key_o = 6'h00;
  // hold long enough to pass the filter, then release
  task automatic press(input int k);
    key_o[k] = 1'b1;
    repeat (6) @(posedge clk_i);
    #1 key_o[k] = 1'b0;
    repeat (6) @(posedge clk_i);
    #1;
  endtask : press
endmodule : drs_panel_model

// file: verif/tb_top.sv
// self-checking bench for the drive reference selector
// assumes an 8-cycle control tick in simulation
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== drs_ref_t'(ex)) begin \
  n_fail++; $display("[ERR] %s exp %0d got %0d", nm, drs_ref_t'(ex), got); end end
module tb_top;
  import drs_pkg::*;
  logic clk, rst, pinc, pdec, pclr, pfb, rrun, z3, run, alc, lact, cl;
  logic [2:0] pdi, pbus, fsq;
  logic [3:0] perm;
  logic [1:0] loopm;
  logic [5:0] key;
  drs_site_e site;
  drs_rfunc_e rfn;
  drs_fbf_e ffn;
  drs_hand_auto_e mode;
  drs_src_e [2:0] src;
  drs_ref_t [7:0] pre;
  drs_ref_t [2:0] fb, sp;
  drs_ref_t busr, pct, ramp, smin, smax, fmax, ana, frq, ecl, nv, lref, aref, cerr, mref, m0;
  int n_fail, total_checks, n_al, cyc;
  // ---------------------------------------------------------------
  // clock, timeout, alarm pulse count
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (alc === 1'b1) n_al++;
    if (cyc == 20000) begin
      n_fail++;
      end_of_test();
    end
  end
  drs_panel_model i_drs_panel_model (.clk_i(clk), .key_o(key));
  drs_selector #(.TICK_CYCLES(8)) i_drs_selector (
    .CLK_SYS_I(clk), .RESET_I(rst), .HAND_KEY_I(key[0]), .OFF_KEY_I(key[1]),
    .AUTO_KEY_I(key[2]), .RESET_KEY_I(key[3]), .NAV_UP_I(key[4]), .NAV_DOWN_I(key[5]),
    .POT_INC_I(pinc), .POT_DEC_I(pdec), .POT_CLR_I(pclr), .PRESET_DI_I(pdi),
    .REMOTE_RUN_I(rrun), .PRESET_BUS_I(pbus), .PRESET_FROM_BUS_I(pfb), .BUS_REF_I(busr),
    .KEY_PERMIT_I(perm), .LOOP_MODE_I(loopm), .REF_SITE_I(site), .REF_FUNC_I(rfn),
    .SRC_SEL_I(src), .PRESET_REF_I(pre), .REL_PCT_I(pct), .RAMP_STEP_I(ramp),
    .SPEED_MIN_I(smin), .SPEED_MAX_I(smax), .FREQ_MAX_I(fmax), .ANALOG_REF_I(ana),
    .FREQ_REF_I(frq), .EXT_CL_REF_I(ecl), .FB_I(fb), .SP_I(sp), .FB_FUNC_I(ffn),
    .FB_SQRT_I(fsq), .ZONE3_I(z3), .LOCAL_REF_NV_I(nv), .RUN_O(run), .MODE_O(mode),
    .LOCAL_ACTIVE_O(lact), .CLOSED_LOOP_O(cl), .ALARM_CLEAR_O(alc), .LOCAL_REF_O(lref),
    .ACTIVE_REF_O(aref), .CTL_ERROR_O(cerr), .MOTOR_REF_O(mref));
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic press(input int k);
    i_drs_panel_model.press(k);
  endtask : press
  task automatic t_keys;
    `CHK("mode", HA_AUTO_OFF, mode)
    `CHK("lref", 250, lref)
    press(K_HAND);
    `CHK("mode", HA_HAND, mode)
    `CHK("run", 1, run)
    `CHK("lact", 1, lact)
    `CHK("cl", 0, cl)
    press(K_UP);
    `CHK("lref", 350, lref)
    press(K_OFF);
    `CHK("run", 0, run)
    perm = 4'h0;
    press(K_AUTO);
    press(K_RST);
    `CHK("mode", HA_HAND_OFF, mode)
    `CHK("alarm", 0, n_al)
    perm = 4'hf;
    press(K_RST);
    `CHK("alarm", 1, n_al)
    press(K_AUTO);
    `CHK("lact", 0, lact)
    `CHK("run", 1, run)
    site = SITE_LOCAL;
    step(3);
    `CHK("cl", 0, cl)
    site = SITE_REMOTE;
    rrun = 1'b0;
    step(3);
    `CHK("cl", 1, cl)
    `CHK("lact", 0, lact)
    `CHK("run", 0, run)
  endtask : t_keys
  task automatic t_ref;
    loopm = LOOP_OPEN;
    src[0] = SRC_ANALOG;
    src[1] = SRC_FREQ;
    src[2] = SRC_EXT_CL;
    step(40);
    `CHK("aref", 4200, aref)
    `CHK("mref", 3000, mref)
    pfb = 1'b1;
    rfn = RF_PRESET;
    pct = 16'sh012c;
    step(40);
    `CHK("aref", -1500, aref)
    `CHK("mref", 0, mref)
    ramp = 16'sh0064;
    rfn = RF_EXT;
    pct = 16'sh0000;
    ana = 16'sh4e20;
    busr = 16'sh4e20;
    step(40);
    `CHK("aref", 20000, aref)
    `CHK("mref", 400, mref)
  endtask : t_ref
  task automatic t_pot;
    src = '0;
    src[0] = SRC_POT;
    busr = 16'sh0000;
    pinc = 1'b1;
    pdec = 1'b1;
    step(40);
    `CHK("pot", 1, (aref > 0 && aref % 10 == 0))
    m0 = aref;
    pinc = 1'b0;
    step(40);
    `CHK("pot", 1, (aref < m0))
    pclr = 1'b1;
    step(24);
    `CHK("pot", 0, aref)
    pclr = 1'b0;
  endtask : t_pot
  task automatic t_loop;
    drs_fbf_e fl[11] = '{FBF_FB1, FBF_FB2, FBF_SUM, FBF_DIFF, FBF_AVG, FBF_MIN,
                         FBF_MAX, FBF_MSP_MIN, FBF_MSP_MAX, FBF_FB1, FBF_MIN};
    int ex[11] = '{-2000, 500, -400, 600, 300, 500, 100, 500, 100, 100, 1000};
    pdec = 1'b0;
    src = '0;
    loopm = 2'h1;
    for (int i = 0; i < 11; i++) begin
      ffn = fl[i];
      fsq = (i == 0) ? 3'h1 : 3'h0;
      z3 = (i == 10);
      step(24);
      `CHK("err", ex[i], cerr)
    end
    z3 = 1'b0;
    ffn = FBF_FB1;
    fb[0] = 16'sh01f4;
    m0 = mref;
    step(32);
    `CHK("rise", 1, (mref > m0))
    fb[0] = 16'sh05dc;
    m0 = mref;
    step(24);
    `CHK("fall", 1, (mref < m0))
  endtask : t_loop
  task automatic end_of_test;
    $display("checks %0d errors %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_of_test
  initial begin
    {rst, pinc, pdec, pclr, pfb, rrun, z3} = 7'b1000010;
    {pdi, pbus, fsq, perm, loopm} = {3'h3, 3'h5, 3'h0, 4'hf, 2'h1};
    site = SITE_LINKED;
    rfn = RF_SUM;
    ffn = FBF_FB1;
    src = '0;
    pre = '0;
    pre[3] = 16'sh07d0;
    pre[5] = -16'sh01f4;
    {busr, pct, ana, frq, ecl, nv} = {16'sh00c8, 16'sh0014, 16'sh03e8, 16'sh012c, 16'sh0, 16'sh00fa};
    {ramp, smin, smax, fmax} = {16'sh4e20, 16'sh0000, 16'sh4e20, 16'sh0bb8};
    fb = {16'sh0, 16'sh01f4, 16'sh0384};
    sp = {16'sh0, 16'sh03e8, 16'sh03e8};
    step(6);
    rst = 1'b0;
    step(3);
    t_keys();
    t_ref();
    fmax = 16'sh4e20;
    t_pot();
    t_loop();
    end_of_test();
  end
endmodule : tb_top
